/* rtl/e3fo_top.sv */
// E3 G.751 frame overhead generator and receive alignment with AXI4-Lite.
//
// Overview of operation
// - G.751 mode when bits 6 and 2 clear
// - Frame is 1536 bits, 12 overhead
// - First ten bits send 1111010000 in order
// - Receiver hunts and keeps the alignment pattern
// - Alarm, national and optional BIP-4 overhead bits
// - 22375 frames per second, 34.368 Mbps
// - Receive trouble sets alarm bit next frame
// - No receive trouble and no BIP-4 FEBE sends alarm bit zero
// - With BIP-4 alarm bit also carries FEBE
// - National bit carries maintenance or user link
//
// The AXI4-Lite register port and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "e3fo_consts.svh"
module e3fo_top
    import e3fo_pkg::*;
(
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic reset,
    // AXI4-Lite write address.
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data.
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response.
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address.
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data.
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Transmit line and terminal side.
    input wire logic tx_payload,
    input wire logic national_in,
    output logic tx_line,
    output logic tx_bit_en,
    output logic tx_frame_end,
    // Receive line and alarm inputs from the line interface.
    input wire logic rx_line,
    input wire logic rx_los,
    input wire logic rx_ais,
    input wire logic febe_in,
    output logic rx_in_frame
);
    // =========================================================
    // Bit rate divider.
    // =========================================================
    // 200 MHz has no integer ratio to 34.368 MHz; a fractional
    // accumulator averages the line rate exactly.
    logic [31:0] acc;
    logic bit_en;
    wire logic [32:0] acc_sum = {1'b0, acc} + 33'(`E3FO_LINE_BPS);
    wire logic acc_wrap = acc_sum >= 33'(`E3FO_CLK_HZ);
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            acc <= 32'h0000_0000;
            bit_en <= 1'b0;
        end else begin
            acc <= acc_wrap ? 32'(acc_sum - 33'(`E3FO_CLK_HZ)) : acc_sum[31:0];
            bit_en <= acc_wrap;
        end
    end
    // =========================================================
    // Input synchronisers.
    // =========================================================
    logic [4:0] sync_a;
    logic [4:0] sync_b;
    wire logic [4:0] pins = {rx_line, rx_los, rx_ais, febe_in, national_in};
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            sync_a <= 5'h00;
            sync_b <= 5'h00;
        end else begin
            sync_a <= pins;
            sync_b <= sync_a;
        end
    end
    wire logic rx_bit = sync_b[4];
    wire logic los_s = sync_b[3];
    wire logic ais_s = sync_b[2];
    wire logic febe_s = sync_b[1];
    wire logic nat_s = sync_b[0];
    // =========================================================
    // Registers.
    // =========================================================
    logic [7:0] mode;
    logic [2:0] ctrl;
    logic [15:0] frame_cnt;
    wire logic g751_mode = !mode[`E3FO_MODE_RATE_BIT] &&
        !mode[`E3FO_MODE_FMT_BIT];
    wire logic bip_en = ctrl[0];
    wire logic user_link = ctrl[1];
    wire logic user_nat = ctrl[2];
    // =========================================================
    // Receive alignment.
    // =========================================================
    logic rx_sync;
    e3fo_rx_align u_align (
        .ref_clk(ref_clk),
        .reset(reset),
        .bit_en(bit_en),
        .rx_bit(rx_bit),
        .in_frame(rx_sync),
        .frame_start()
    );
    wire logic rx_trouble = los_s || ais_s || !rx_sync;
    // =========================================================
    // Transmit framer.
    // =========================================================
    logic [10:0] tx_pos;
    logic alarm_lat;
    logic [3:0] bip_acc;
    logic [3:0] bip_hold;
    wire logic frame_last = (tx_pos == `E3FO_FRAME_LAST);
    wire logic in_fas = (tx_pos < `E3FO_FAS_LEN);
    wire logic in_bip = bip_en && (tx_pos >= `E3FO_POS_BIP);
    wire logic [3:0] fas_idx = 4'(`E3FO_FAS_LEN - 11'd1 - tx_pos);
    wire logic [3:0] bip_idx = 4'(`E3FO_FRAME_LAST - tx_pos);
    wire logic fas_bit = 1'(`E3FO_FAS >> fas_idx);
    wire logic alarm_bit = alarm_lat || (bip_en && febe_s);
    wire logic nat_bit = user_link ? user_nat : nat_s;
    wire logic next_tx =
        in_fas ? fas_bit :
        (tx_pos == `E3FO_POS_ALARM) ? alarm_bit :
        (tx_pos == `E3FO_POS_NAT) ? nat_bit :
        in_bip ? bip_hold[bip_idx[1:0]] : tx_payload;
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            tx_pos <= 11'h000;
            alarm_lat <= 1'b0;
            bip_acc <= 4'h0;
            bip_hold <= 4'h0;
            tx_line <= 1'b0;
            tx_frame_end <= 1'b0;
            frame_cnt <= 16'h0000;
        end else if (bit_en && g751_mode) begin
            tx_pos <= frame_last ? 11'h000 : tx_pos + 11'd1;
            tx_line <= next_tx;
            tx_frame_end <= frame_last;
            if (frame_last) begin
                alarm_lat <= rx_trouble;
                bip_hold <= bip_acc;
                bip_acc <= 4'h0;
                frame_cnt <= frame_cnt + 16'h0001;
            end else if (!in_bip) begin
                bip_acc[tx_pos[1:0]] <= bip_acc[tx_pos[1:0]] ^ next_tx;
            end
        end else begin
            tx_frame_end <= 1'b0;
        end
    end
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            tx_bit_en <= 1'b0;
            rx_in_frame <= 1'b0;
        end else begin
            tx_bit_en <= bit_en && g751_mode;
            rx_in_frame <= rx_sync;
        end
    end
    // =========================================================
    // AXI4-Lite slave.
    // =========================================================
    logic aw_full;
    logic w_full;
    logic [3:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    wire logic do_write = aw_full && w_full && !s_axi_bvalid;
    wire logic wr_mode = (aw_addr == `E3FO_ADDR_MODE);
    wire logic wr_ctrl = (aw_addr == `E3FO_ADDR_CTRL);
    wire logic wr_hit = wr_mode || wr_ctrl;
    wire logic rd_take = s_axi_arvalid && s_axi_arready;
    wire logic [31:0] status_word = {29'h0, g751_mode, alarm_lat, rx_sync};
    wire logic rd_hit = (s_axi_araddr == `E3FO_ADDR_MODE) ||
        (s_axi_araddr == `E3FO_ADDR_CTRL) ||
        (s_axi_araddr == `E3FO_ADDR_STAT) ||
        (s_axi_araddr == `E3FO_ADDR_CNT);
    wire logic [31:0] rd_word =
        (s_axi_araddr == `E3FO_ADDR_MODE) ? {24'h0, mode} :
        (s_axi_araddr == `E3FO_ADDR_CTRL) ? {29'h0, ctrl} :
        (s_axi_araddr == `E3FO_ADDR_STAT) ? status_word :
        (s_axi_araddr == `E3FO_ADDR_CNT) ? {16'h0, frame_cnt} : 32'h0;
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            aw_addr <= 4'h0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `E3FO_AXI_OKAY;
        end else begin
            s_axi_awready <= !aw_full && !s_axi_awready;
            s_axi_wready <= !w_full && !s_axi_wready;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full <= 1'b1;
                aw_addr <= {s_axi_awaddr[3:2], 2'b00};
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_full <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_full <= 1'b0;
                w_full <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? `E3FO_AXI_OKAY : `E3FO_AXI_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            mode <= `E3FO_MODE_RESET;
            ctrl <= 3'h0;
        end else if (do_write && w_strb[0]) begin
            if (wr_mode) mode <= w_data[7:0];
            if (wr_ctrl) ctrl <= w_data[2:0];
        end
    end
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `E3FO_AXI_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
            if (rd_take) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_word;
                s_axi_rresp <= rd_hit ? `E3FO_AXI_OKAY : `E3FO_AXI_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
    // =========================================================
    // Assertions.
    // =========================================================
    property p_frame_len;
        @(posedge ref_clk) disable iff (reset)
        (tx_pos == `E3FO_FRAME_LAST && bit_en && g751_mode) |=> tx_pos == 11'h000;
    endproperty
    a_frame_len: assert property (p_frame_len) else $error("Frame wrap wrong.");
    property p_fas;
        @(posedge ref_clk) disable iff (reset)
        (bit_en && g751_mode && in_fas) |=> tx_line == $past(fas_bit);
    endproperty
    a_fas: assert property (p_fas) else $error("Alignment bit wrong.");
    property p_alarm_set;
        @(posedge ref_clk) disable iff (reset)
        (bit_en && g751_mode && tx_pos == `E3FO_POS_ALARM && alarm_lat)
        |=> tx_line;
    endproperty
    a_alarm_set: assert property (p_alarm_set) else $error("Alarm not sent.");
    property p_alarm_clr;
        @(posedge ref_clk) disable iff (reset)
        (bit_en && g751_mode && tx_pos == `E3FO_POS_ALARM && !alarm_lat &&
         !bip_en) |=> !tx_line;
    endproperty
    a_alarm_clr: assert property (p_alarm_clr) else $error("Alarm set idle.");
    property p_latch;
        @(posedge ref_clk) disable iff (reset)
        (bit_en && g751_mode && frame_last) |=> alarm_lat == $past(rx_trouble);
    endproperty
    a_latch: assert property (p_latch) else $error("Alarm latch wrong.");
    property p_mode;
        @(posedge ref_clk) disable iff (reset)
        !g751_mode |=> !tx_bit_en;
    endproperty
    a_mode: assert property (p_mode) else $error("Framer ran outside mode.");
    property p_nat;
        @(posedge ref_clk) disable iff (reset)
        (bit_en && g751_mode && tx_pos == `E3FO_POS_NAT && user_link)
        |=> tx_line == $past(user_nat);
    endproperty
    a_nat: assert property (p_nat) else $error("National bit wrong.");
    property p_bresp;
        @(posedge ref_clk) disable iff (reset)
        do_write |=> s_axi_bvalid;
    endproperty
    a_bresp: assert property (p_bresp) else $error("Write got no answer.");
    property p_rate;
        @(posedge ref_clk) disable iff (reset)
        bit_en |=> !bit_en ##1 !bit_en;
    endproperty
    a_rate: assert property (p_rate) else $error("Bit enable too fast.");
    c_frame: cover property (@(posedge ref_clk) tx_frame_end);
    c_sync: cover property (@(posedge ref_clk) rx_in_frame);
    c_alarm: cover property (@(posedge ref_clk) alarm_lat);
    c_write: cover property (@(posedge ref_clk) do_write && wr_mode);
endmodule
`default_nettype wire

/* common/e3fo_consts.svh */
// Constants for the E3 G.751 frame overhead block.
`ifndef E3FO_CONSTS_SVH
`define E3FO_CONSTS_SVH
`define E3FO_ADDR_MODE 4'h0
`define E3FO_ADDR_CTRL 4'h4
`define E3FO_ADDR_STAT 4'h8
`define E3FO_ADDR_CNT 4'hC
`define E3FO_MODE_RATE_BIT 6
`define E3FO_MODE_FMT_BIT 2
`define E3FO_MODE_RESET 8'h44
`define E3FO_FRAME_LEN 11'd1536
`define E3FO_FRAME_LAST 11'd1535
`define E3FO_OH_BITS 12
`define E3FO_PAYLOAD_BITS 1524
`define E3FO_FAS_LEN 11'd10
`define E3FO_FAS 10'b11_1101_0000
`define E3FO_POS_ALARM 11'd10
`define E3FO_POS_NAT 11'd11
`define E3FO_POS_BIP 11'd1532
`define E3FO_FRAMES_PER_SEC 22375
`define E3FO_LINE_BPS 34368000
`define E3FO_CLK_HZ 200000000
`define E3FO_DIV_W 8
`define E3FO_BIT_DIV 8'h05
`define E3FO_LOCK_FRAMES 2'h3
`define E3FO_AXI_OKAY 2'b00
`define E3FO_AXI_SLVERR 2'b10
`endif

/* common/e3fo_pkg.sv */
// Types for the E3 G.751 frame overhead block.
package e3fo_pkg;
    typedef enum logic [1:0] {
        E3FO_HUNT = 2'b00,
        E3FO_CHECK = 2'b01,
        E3FO_SYNC = 2'b10
    } e3fo_sync_t;
endpackage

/* rtl/e3fo_rx_align.sv */
// Receive frame alignment search for the E3 G.751 stream.
`timescale 1ns/1ps
`default_nettype none
`include "e3fo_consts.svh"
module e3fo_rx_align
    import e3fo_pkg::*;
(
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic reset,
    // Serial receive bit and its enable.
    input wire logic bit_en,
    input wire logic rx_bit,
    // Alignment state.
    output logic in_frame,
    output logic frame_start
);
    e3fo_sync_t state;
    e3fo_sync_t next_state;
    logic [9:0] shift;
    logic [10:0] pos;
    logic [1:0] hits;
    wire logic [9:0] window = {shift[8:0], rx_bit};
    wire logic fas_hit = (window == `E3FO_FAS);
    wire logic at_fas_end = (pos == `E3FO_FAS_LEN - 11'd1);
    wire logic hunting = (state == E3FO_HUNT);
    // The pattern is checked at the tenth bit of each frame once found.
    always_comb begin
        next_state = state;
        unique case (state)
            E3FO_HUNT: if (fas_hit) next_state = E3FO_CHECK;
            E3FO_CHECK: if (at_fas_end) begin
                if (!fas_hit) next_state = E3FO_HUNT;
                else if (hits == `E3FO_LOCK_FRAMES - 2'h1)
                    next_state = E3FO_SYNC;
            end
            E3FO_SYNC: if (at_fas_end && !fas_hit) next_state = E3FO_HUNT;
            default: next_state = E3FO_HUNT;
        endcase
    end
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            state <= E3FO_HUNT;
            shift <= 10'h000;
            pos <= 11'h000;
            hits <= 2'h0;
        end else if (bit_en) begin
            state <= next_state;
            shift <= window;
            // A fresh hit means the next bit follows the pattern.
            if (hunting && fas_hit)
                pos <= `E3FO_FAS_LEN;
            else if (pos == `E3FO_FRAME_LAST)
                pos <= 11'h000;
            else
                pos <= pos + 11'd1;
            if (hunting)
                hits <= 2'h0;
            else if (at_fas_end && fas_hit)
                hits <= hits + 2'h1;
        end
    end
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            in_frame <= 1'b0;
            frame_start <= 1'b0;
        end else begin
            in_frame <= (state == E3FO_SYNC);
            frame_start <= bit_en && pos == `E3FO_FRAME_LAST;
        end
    end
    property p_hunt_on_miss;
        @(posedge ref_clk) disable iff (reset)
        (bit_en && state == E3FO_SYNC && at_fas_end && !fas_hit)
        |=> state == E3FO_HUNT;
    endproperty
    a_hunt_on_miss: assert property (p_hunt_on_miss)
        else $error("Missed pattern did not drop alignment.");
endmodule
`default_nettype wire

/* verif/e3fo_remote_term.sv */
// Remote E3 terminal model: sends G.751 frames and watches the overhead.
`timescale 1ns/1ps
`default_nettype none
`include "e3fo_consts.svh"
module e3fo_remote_term #(
    parameter int FAIL_RUN = 2
) (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic reset,
    // Line from the framer.
    input wire logic tx_line,
    input wire logic tx_bit_en,
    // Line towards the framer.
    output logic rx_line,
    // Overhead seen in the last frame.
    output logic frame_tick,
    output logic alarm_seen,
    output logic nat_seen,
    output logic far_fail,
    output logic [10:0] frame_bits,
    output logic [15:0] frame_cycles
);
    localparam logic [9:0] FAS_W = `E3FO_FAS;
    logic [3:0] en_dly;
    logic [9:0] hist;
    logic [9:0] next_hist;
    logic [1:0] oh_pos;
    logic [10:0] gen_pos;
    logic [10:0] bit_cnt;
    logic [15:0] cyc_cnt;
    logic [2:0] run_cnt;
    logic fas_hit;
    // Payload is kept at zero, so the pattern only shows in the overhead.
    assign next_hist = {hist[8:0], tx_line};
    assign fas_hit = en_dly[3] && (next_hist == FAS_W);
    assign far_fail = (run_cnt >= 3'(FAIL_RUN));
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            en_dly <= 4'h0;
            hist <= 10'h000;
            oh_pos <= 2'h0;
            gen_pos <= 11'h000;
            bit_cnt <= 11'h000;
            cyc_cnt <= 16'h0000;
            run_cnt <= 3'h0;
            rx_line <= 1'b0;
            frame_tick <= 1'b0;
            alarm_seen <= 1'b0;
            nat_seen <= 1'b0;
            frame_bits <= 11'h000;
            frame_cycles <= 16'h0000;
        end else begin
            en_dly <= {en_dly[2:0], tx_bit_en};
            cyc_cnt <= fas_hit ? 16'h0000 : cyc_cnt + 16'h0001;
            frame_tick <= en_dly[3] && (oh_pos == 2'h2);
            if (tx_bit_en) begin
                gen_pos <= (gen_pos == 11'h5ff) ? 11'h000 : gen_pos + 11'h001;
                rx_line <= (gen_pos < 11'h00a) && FAS_W[4'h9 - gen_pos[3:0]];
            end
            if (en_dly[3]) begin
                hist <= next_hist;
                bit_cnt <= fas_hit ? 11'h000 : bit_cnt + 11'h001;
                oh_pos <= fas_hit ? 2'h1 : ((oh_pos == 2'h1) ? 2'h2 : 2'h0);
                if (fas_hit) begin
                    frame_bits <= bit_cnt + 11'h001;
                    frame_cycles <= cyc_cnt + 16'h0001;
                end
                if (oh_pos == 2'h1) begin
                    alarm_seen <= tx_line;
                end
                if (oh_pos == 2'h2) begin
                    nat_seen <= tx_line;
                    run_cnt <= !alarm_seen ? 3'h0 : run_cnt + 3'(run_cnt != 3'h7);
                end
            end
        end
    end
endmodule
`default_nettype wire

/* verif/e3fo_top_tb_top.sv */
// Testbench for the E3 G.751 frame overhead block.
`timescale 1ns/1ps
`default_nettype none
`include "e3fo_consts.svh"
module e3fo_top_tb_top;
    logic ref_clk, reset;
    logic [3:0] awaddr, araddr, wstrb;
    logic [31:0] wdata, rdata;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [1:0] bresp, rresp;
    logic tx_payload, national_in, tx_line, tx_bit_en, tx_frame_end;
    logic rx_line, rx_los, rx_ais, febe_in, rx_in_frame;
    logic frame_tick, alarm_seen, nat_seen, far_fail;
    logic [10:0] frame_bits;
    logic [15:0] frame_cycles;
    logic [10:0] fe_cnt, fe_bits;
    int num_errors = 0;
    int cmp_count = 0;

    e3fo_top e3fo_top_inst (
        .ref_clk(ref_clk), .reset(reset),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .tx_payload(tx_payload), .national_in(national_in), .tx_line(tx_line),
        .tx_bit_en(tx_bit_en), .tx_frame_end(tx_frame_end),
        .rx_line(rx_line), .rx_los(rx_los), .rx_ais(rx_ais),
        .febe_in(febe_in), .rx_in_frame(rx_in_frame)
    );
    e3fo_remote_term #(.FAIL_RUN(2)) e3fo_remote_term_inst (
        .ref_clk(ref_clk), .reset(reset), .tx_line(tx_line),
        .tx_bit_en(tx_bit_en), .rx_line(rx_line), .frame_tick(frame_tick),
        .alarm_seen(alarm_seen), .nat_seen(nat_seen), .far_fail(far_fail),
        .frame_bits(frame_bits), .frame_cycles(frame_cycles)
    );

    always #2.5 ref_clk = ~ref_clk;

    // Counts line bits between frame end marks of the transmitter.
    always @(posedge ref_clk) begin
        if (reset) begin
            fe_cnt <= 11'h000;
            fe_bits <= 11'h000;
        end else if (tx_frame_end === 1'b1) begin
            fe_bits <= fe_cnt + 11'h001;
            fe_cnt <= 11'h000;
        end else if (tx_bit_en === 1'b1) begin
            fe_cnt <= fe_cnt + 11'h001;
        end
    end

    // ==========
    // Shared tasks.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // One AXI4-Lite write or read; waits for the answer however long it takes.
    task automatic axi(input logic wr, input logic [3:0] addr,
                       input logic [31:0] data, output logic [31:0] rd,
                       output logic [1:0] resp);
        logic a_done, w_done, done;
        @(posedge ref_clk);
        a_done = 1'b0;
        w_done = !wr;
        done = 1'b0;
        if (wr) begin
            awaddr <= addr;
            awvalid <= 1'b1;
            wdata <= data;
            wvalid <= 1'b1;
            bready <= 1'b1;
        end else begin
            araddr <= addr;
            arvalid <= 1'b1;
            rready <= 1'b1;
        end
        while (!done) begin
            @(posedge ref_clk);
            if (a_done && w_done && (wr ? bvalid : rvalid) === 1'b1) begin
                done = 1'b1;
                rd = rdata;
                resp = wr ? bresp : rresp;
                bready <= 1'b0;
                rready <= 1'b0;
            end
            if (!a_done && (wr ? awready : arready) === 1'b1) begin
                a_done = 1'b1;
                awvalid <= 1'b0;
                arvalid <= 1'b0;
            end
            if (!w_done && wready === 1'b1) begin
                w_done = 1'b1;
                wvalid <= 1'b0;
            end
        end
    endtask

    task automatic wait_ticks(input int n);
        repeat (n) begin
            do @(posedge ref_clk); while (frame_tick !== 1'b1);
        end
    endtask

    // ==========
    // Scenarios.
    task automatic t_reset_state();
        logic [31:0] rd;
        logic [1:0] rs;
        int pulses;
        axi(1'b0, `E3FO_ADDR_MODE, 32'h0000_0000, rd, rs);
        check(rd, {24'h00_0000, `E3FO_MODE_RESET});
        axi(1'b1, `E3FO_ADDR_STAT, 32'h0000_0000, rd, rs);
        check({30'h0000_0000, rs}, {30'h0000_0000, `E3FO_AXI_SLVERR});
        for (int i = 0; i < 2; i++) begin
            axi(1'b1, `E3FO_ADDR_MODE, i ? 32'h0000_0040 : 32'h0000_0004, rd, rs);
            pulses = 0;
            repeat (300) begin
                @(posedge ref_clk);
                if (tx_bit_en !== 1'b0) pulses++;
            end
            check(32'(pulses), 32'h0000_0000);
        end
    endtask

    task automatic t_enter();
        logic [31:0] rd;
        logic [1:0] rs;
        axi(1'b1, `E3FO_ADDR_CTRL, 32'h0000_0006, rd, rs);
        axi(1'b1, `E3FO_ADDR_MODE, 32'h0000_0000, rd, rs);
        axi(1'b0, `E3FO_ADDR_STAT, 32'h0000_0000, rd, rs);
        check({31'h0000_0000, rd[2]}, 32'h0000_0001);
        wait_ticks(2);
        check({21'h00_0000, frame_bits}, 32'h0000_0600);
        check({21'h00_0000, fe_bits}, 32'h0000_0600);
        check(32'(frame_cycles >= 16'h22ea && frame_cycles <= 16'h22ec), 32'h1);
        check({31'h0000_0000, alarm_seen}, 32'h0000_0001);
        check({31'h0000_0000, nat_seen}, 32'h0000_0001);
    endtask

    task automatic t_lock();
        logic [31:0] rd;
        logic [1:0] rs;
        int n;
        n = 0;
        while (rx_in_frame !== 1'b1 && n < 50000) begin
            @(posedge ref_clk);
            n++;
        end
        check({31'h0000_0000, rx_in_frame}, 32'h0000_0001);
        national_in <= 1'b0;
        axi(1'b1, `E3FO_ADDR_CTRL, 32'h0000_0000, rd, rs);
        wait_ticks(2);
        check({31'h0000_0000, alarm_seen}, 32'h0000_0000);
        check({31'h0000_0000, nat_seen}, 32'h0000_0000);
        check({31'h0000_0000, far_fail}, 32'h0000_0000);
    endtask

    task automatic t_alarms();
        logic [31:0] rd;
        logic [1:0] rs;
        rx_los <= 1'b1;
        national_in <= 1'b1;
        wait_ticks(2);
        check({31'h0000_0000, alarm_seen}, 32'h0000_0001);
        check({31'h0000_0000, nat_seen}, 32'h0000_0001);
        check({31'h0000_0000, far_fail}, 32'h0000_0001);
        rx_los <= 1'b0;
        rx_ais <= 1'b1;
        wait_ticks(1);
        check({31'h0000_0000, alarm_seen}, 32'h0000_0001);
        rx_ais <= 1'b0;
        febe_in <= 1'b1;
        axi(1'b1, `E3FO_ADDR_CTRL, 32'h0000_0001, rd, rs);
        wait_ticks(1);
        check({31'h0000_0000, alarm_seen}, 32'h0000_0001);
        check({21'h00_0000, frame_bits}, 32'h0000_0600);
        check({31'h0000_0000, rx_in_frame}, 32'h0000_0001);
    endtask

    initial begin
        ref_clk = 1'b0;
        reset = 1'b1;
        {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
        wstrb = 4'hf;
        {tx_payload, national_in, rx_los, rx_ais, febe_in} = '0;
        repeat (12) @(posedge ref_clk);
        reset <= 1'b0;
        t_reset_state();
        t_enter();
        t_lock();
        t_alarms();
        wrap_up();
    end

    initial begin
        repeat (95000) @(posedge ref_clk);
        num_errors++;
        wrap_up();
    end
endmodule
`default_nettype wire
